// ### inc/pem_pkg.sv
// constants, limits and state type for the parameter error monitor
package pem_pkg;

	// setting word width and number of plain range checks
	localparam int SET_W   = 16;
	localparam int NUM_CHK = 10;

	// index of each setting in the range-check array
	localparam int IDX_H_OFFSET   = 0;
	localparam int IDX_WIDTH      = 1;
	localparam int IDX_V_OFFSET   = 2;
	localparam int IDX_HEIGHT     = 3;
	localparam int IDX_BANDWIDTH  = 4;
	localparam int IDX_EXPOSURE   = 5;
	localparam int IDX_GAIN       = 6;
	localparam int IDX_BRIGHTNESS = 7;
	localparam int IDX_BAL_UB     = 8;
	localparam int IDX_BAL_VR     = 9;

	// sensor frame extent, bounds offset plus size
	localparam logic [SET_W-1:0] FRAME_COLS = 16'h0290;
	localparam logic [SET_W-1:0] FRAME_ROWS = 16'h01EB;

	// lower and upper limits, one per check index
	localparam logic [SET_W-1:0] LIMIT_LO [NUM_CHK] = '{
		16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0001,
		16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [SET_W-1:0] LIMIT_HI [NUM_CHK] = '{
		16'h028F, 16'h0290, 16'h01EA, 16'h01EB, 16'h0064,
		16'h0FFF, 16'h03FF, 16'h00FF, 16'h01FF, 16'h01FF};

	// colour coding and trigger field widths and legal counts
	localparam int                CODE_W      = 4;
	localparam logic [CODE_W-1:0] COLOUR_CODES = 4'h4;
	localparam logic [CODE_W-1:0] TRIG_POLS    = 4'h2;
	localparam logic [CODE_W-1:0] TRIG_SRCS    = 4'h3;
	localparam logic [CODE_W-1:0] TRIG_MODES   = 4'h3;
	localparam logic [CODE_W-1:0] TRIG_SRC_INT = 4'h0;
	localparam logic [CODE_W-1:0] TRIG_SRC_SW  = 4'h2;
	localparam logic [CODE_W-1:0] TRIG_MODE_FREE  = 4'h0;
	localparam logic [CODE_W-1:0] TRIG_MODE_LEVEL = 4'h2;

	// temperature in whole degrees, signed
	localparam int               TEMP_W     = 8;
	localparam logic [TEMP_W-1:0] TEMP_LIMIT = 8'h46;

	// supply measurement in millivolts, with hysteresis
	localparam int                 SUPPLY_W       = 16;
	localparam logic [SUPPLY_W-1:0] SUPPLY_LOCK_MV = 16'h2710;
	localparam logic [SUPPLY_W-1:0] SUPPLY_RUN_MV  = 16'h2CEC;

	// startup sequence length
	localparam int CLK_MHZ        = 40;
	localparam int STARTUP_US     = 100;
	localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
	localparam int STARTUP_W      = 12;

	// power sequencing states
	typedef enum logic [1:0] {
		PWR_LOCKOUT,
		PWR_STARTUP,
		PWR_RUN,
		PWR_HOT
	} power_state_t;

endpackage : pem_pkg

// ### src/range_check.sv
// inclusive range comparator for one setting word
`timescale 1ns/100ps
module range_check #(
	parameter int WIDTH = 16
) (
	// value and its limits
	input  wire logic [WIDTH-1:0] value_i,
	input  wire logic [WIDTH-1:0] lo_i,
	input  wire logic [WIDTH-1:0] hi_i,
	// result
	output wire logic             out_of_range_o
);

	// unsigned compare, both ends inclusive
	assign out_of_range_o = (value_i < lo_i) || (value_i > hi_i);

endmodule : range_check

// ### src/parameter_error_monitor.sv
// setting error flags, temperature watch and power sequencing
`timescale 1ns/100ps
module parameter_error_monitor
	import pem_pkg::*;
(
	// clock, reset, enable
	input  wire logic                clock_i,
	input  wire logic                arst_n_i,
	input  wire logic                ce_i,
	// imaging window settings
	input  wire logic [SET_W-1:0]    h_offset_i,
	input  wire logic [SET_W-1:0]    width_i,
	input  wire logic [SET_W-1:0]    v_offset_i,
	input  wire logic [SET_W-1:0]    height_i,
	input  wire logic [CODE_W-1:0]   colour_code_i,
	// scalar settings
	input  wire logic [SET_W-1:0]    bandwidth_i,
	input  wire logic [SET_W-1:0]    exposure_i,
	input  wire logic [SET_W-1:0]    gain_i,
	input  wire logic [SET_W-1:0]    brightness_i,
	input  wire logic [SET_W-1:0]    balance_ub_i,
	input  wire logic [SET_W-1:0]    balance_vr_i,
	// trigger settings
	input  wire logic [CODE_W-1:0]   trig_polarity_i,
	input  wire logic [CODE_W-1:0]   trig_source_i,
	input  wire logic [CODE_W-1:0]   trig_mode_i,
	// sensors
	input  wire logic [TEMP_W-1:0]   processor_temp_raw_i,
	input  wire logic [TEMP_W-1:0]   board_temp_raw_i,
	input  wire logic [SUPPLY_W-1:0] supply_mv_i,
	// error flags
	output logic                     window_format_fault_o,
	output logic                     bandwidth_fault_o,
	output logic                     exposure_fault_o,
	output logic                     gain_fault_o,
	output logic                     brightness_fault_o,
	output logic                     trigger_setup_fault_o,
	output logic                     colour_balance_fault_o,
	// temperature readings
	output logic [TEMP_W-1:0]        processor_temp_reading_o,
	output logic [TEMP_W-1:0]        board_temp_reading_o,
	// power status and control
	output logic                     overtemp_o,
	output logic                     lockout_o,
	output logic                     power_gen_en_o,
	output logic                     power_led_o,
	output logic                     core_reset_n_o
);

	// gather the plain range checks into one array
	logic [SET_W-1:0] chk_val [NUM_CHK];
	logic [NUM_CHK-1:0] chk_bad;

	assign chk_val[IDX_H_OFFSET]   = h_offset_i;
	assign chk_val[IDX_WIDTH]      = width_i;
	assign chk_val[IDX_V_OFFSET]   = v_offset_i;
	assign chk_val[IDX_HEIGHT]     = height_i;
	assign chk_val[IDX_BANDWIDTH]  = bandwidth_i;
	assign chk_val[IDX_EXPOSURE]   = exposure_i;
	assign chk_val[IDX_GAIN]       = gain_i;
	assign chk_val[IDX_BRIGHTNESS] = brightness_i;
	assign chk_val[IDX_BAL_UB]     = balance_ub_i;
	assign chk_val[IDX_BAL_VR]     = balance_vr_i;

	// one comparator per setting
	for (genvar i = 0; i < NUM_CHK; i++) begin : g_chk
		range_check #(
			.WIDTH (SET_W)
		) u_chk (
			.value_i        (chk_val[i]),
			.lo_i           (LIMIT_LO[i]),
			.hi_i           (LIMIT_HI[i]),
			.out_of_range_o (chk_bad[i])
		);
	end

	// a code field is legal when below its count
	function automatic logic code_bad(input logic [CODE_W-1:0] code, input logic [CODE_W-1:0] cnt);
		code_bad = (code >= cnt);
	endfunction : code_bad

	// window: one extra bit so offset plus size cannot wrap
	wire [SET_W:0] h_end = {1'b0, h_offset_i} + {1'b0, width_i};
	wire [SET_W:0] v_end = {1'b0, v_offset_i} + {1'b0, height_i};
	wire window_conflict = (h_end > {1'b0, FRAME_COLS}) || (v_end > {1'b0, FRAME_ROWS});
	wire window_bad = chk_bad[IDX_H_OFFSET] | chk_bad[IDX_WIDTH]
		| chk_bad[IDX_V_OFFSET] | chk_bad[IDX_HEIGHT]
		| code_bad(colour_code_i, COLOUR_CODES) | window_conflict;

	// trigger: free run needs internal source, edge needs external or software, level needs external
	wire trig_conflict = ((trig_mode_i == TRIG_MODE_FREE) != (trig_source_i == TRIG_SRC_INT))
		|| ((trig_mode_i == TRIG_MODE_LEVEL) && (trig_source_i == TRIG_SRC_SW));
	wire trig_bad = code_bad(trig_polarity_i, TRIG_POLS)
		| code_bad(trig_source_i, TRIG_SRCS)
		| code_bad(trig_mode_i, TRIG_MODES) | trig_conflict;

	// flags are recomputed every enabled cycle, so no clear is ever needed
	always_ff @(posedge clock_i or negedge arst_n_i) begin : p_flags
		if (!arst_n_i) begin
			window_format_fault_o  <= 1'b0;
			bandwidth_fault_o      <= 1'b0;
			exposure_fault_o       <= 1'b0;
			gain_fault_o           <= 1'b0;
			brightness_fault_o     <= 1'b0;
			trigger_setup_fault_o  <= 1'b0;
			colour_balance_fault_o <= 1'b0;
		end else if (ce_i) begin
			window_format_fault_o  <= window_bad;
			bandwidth_fault_o      <= chk_bad[IDX_BANDWIDTH];
			exposure_fault_o       <= chk_bad[IDX_EXPOSURE];
			gain_fault_o           <= chk_bad[IDX_GAIN];
			brightness_fault_o     <= chk_bad[IDX_BRIGHTNESS];
			trigger_setup_fault_o  <= trig_bad;
			colour_balance_fault_o <= chk_bad[IDX_BAL_UB] | chk_bad[IDX_BAL_VR];
		end
	end

	// temperature readings held for software, kept live even when hot
	always_ff @(posedge clock_i or negedge arst_n_i) begin : p_temp
		if (!arst_n_i) begin
			processor_temp_reading_o <= '0;
			board_temp_reading_o     <= '0;
		end else if (ce_i) begin
			processor_temp_reading_o <= processor_temp_raw_i;
			board_temp_reading_o     <= board_temp_raw_i;
		end
	end

	// compare the registered readings, signed degrees
	wire too_hot = ($signed(processor_temp_reading_o) >= $signed(TEMP_LIMIT))
		|| ($signed(board_temp_reading_o) >= $signed(TEMP_LIMIT));
	wire supply_low = supply_mv_i < SUPPLY_LOCK_MV;
	wire supply_ok  = supply_mv_i >= SUPPLY_RUN_MV;

	// power sequencer state and startup counter
	power_state_t         state_q, state_d;
	logic [STARTUP_W-1:0] start_cnt_q, start_cnt_d;
	localparam logic [STARTUP_W-1:0] START_LAST = STARTUP_W'(STARTUP_CYCLES - 1);

	// hot beats everything; only a reset (power cycle) leaves it
	always_comb begin : p_next
		state_d     = state_q;
		start_cnt_d = start_cnt_q;
		case (state_q)
			PWR_HOT: begin
				state_d = PWR_HOT;
			end
			PWR_LOCKOUT: begin
				start_cnt_d = '0;
				if (supply_ok) begin
					state_d = PWR_STARTUP;
				end
			end
			PWR_STARTUP: begin
				if (supply_low) begin
					state_d = PWR_LOCKOUT;
				end else if (start_cnt_q == START_LAST) begin
					state_d = PWR_RUN;
				end else begin
					start_cnt_d = start_cnt_q + 1'b1;
				end
			end
			PWR_RUN: begin
				if (supply_low) begin
					state_d = PWR_LOCKOUT;
				end
			end
			default: begin
				state_d = PWR_LOCKOUT;
			end
		endcase
		if (too_hot) begin
			state_d = PWR_HOT;
		end
	end

	// after reset the unit waits for a good supply, as after power-on
	always_ff @(posedge clock_i or negedge arst_n_i) begin : p_state
		if (!arst_n_i) begin
			state_q     <= PWR_LOCKOUT;
			start_cnt_q <= '0;
		end else if (ce_i) begin
			state_q     <= state_d;
			start_cnt_q <= start_cnt_d;
		end
	end

	// status outputs taken from next state so they track state_q exactly
	wire run_d   = (state_d == PWR_RUN);
	wire power_d = (state_d == PWR_RUN) || (state_d == PWR_STARTUP);
	always_ff @(posedge clock_i or negedge arst_n_i) begin : p_pwr_out
		if (!arst_n_i) begin
			overtemp_o     <= 1'b0;
			lockout_o      <= 1'b1;
			power_gen_en_o <= 1'b0;
			power_led_o    <= 1'b0;
			core_reset_n_o <= 1'b0;
		end else if (ce_i) begin
			overtemp_o     <= (state_d == PWR_HOT);
			lockout_o      <= (state_d == PWR_LOCKOUT);
			power_gen_en_o <= power_d;
			power_led_o    <= power_d;
			core_reset_n_o <= run_d;
		end
	end

endmodule : parameter_error_monitor

// ### bench/pem_checker.sv
// assertion checker watching the parameter error monitor ports
`timescale 1ns/100ps
module pem_checker
	import pem_pkg::*;
(
	// clock, reset, enable
	input wire logic                clock_i,
	input wire logic                arst_n_i,
	input wire logic                ce_i,
	// settings and supply
	input wire logic [SET_W-1:0]    bandwidth_i,
	input wire logic [SET_W-1:0]    exposure_i,
	input wire logic [SET_W-1:0]    gain_i,
	input wire logic [SET_W-1:0]    brightness_i,
	input wire logic [SET_W-1:0]    balance_ub_i,
	input wire logic [SET_W-1:0]    balance_vr_i,
	input wire logic [SUPPLY_W-1:0] supply_mv_i,
	// outputs under watch
	input wire logic                bandwidth_fault_o,
	input wire logic                exposure_fault_o,
	input wire logic                gain_fault_o,
	input wire logic                brightness_fault_o,
	input wire logic                colour_balance_fault_o,
	input wire logic [TEMP_W-1:0]   board_temp_reading_o,
	input wire logic                overtemp_o,
	input wire logic                lockout_o,
	input wire logic                power_gen_en_o,
	input wire logic                power_led_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	// previous edge was out of reset and enabled, so flags track it
	sequence s_live;
		$past(ce_i && arst_n_i);
	endsequence
	sequence s_hot;
		ce_i && $signed(board_temp_reading_o) >= $signed(TEMP_LIMIT) ##1 ce_i;
	endsequence
	sequence s_low;
		ce_i && supply_mv_i < SUPPLY_LOCK_MV ##1 ce_i;
	endsequence

	AST_BANDWIDTH: assert property (
		s_live |-> bandwidth_fault_o == !($past(bandwidth_i) inside {[1:100]}))
		else $error("bandwidth flag wrong");
	AST_EXPOSURE: assert property (
		s_live |-> exposure_fault_o == !($past(exposure_i) inside {[1:4095]}))
		else $error("exposure flag wrong");
	AST_GAIN: assert property (
		s_live |-> gain_fault_o == ($past(gain_i) > 1023))
		else $error("gain flag wrong");
	AST_BRIGHT: assert property (
		s_live |-> brightness_fault_o == ($past(brightness_i) > 255))
		else $error("brightness flag wrong");
	AST_BALANCE: assert property (
		s_live |-> colour_balance_fault_o == ($past(balance_ub_i) > 511 || $past(balance_vr_i) > 511))
		else $error("balance flag wrong");
	AST_HOT_ENTRY: assert property (
		s_hot |=> overtemp_o)
		else $error("overtemperature not entered");
	AST_HOT_HOLD: assert property (
		overtemp_o |-> !power_led_o && !power_gen_en_o ##1 overtemp_o)
		else $error("overtemperature not held dark");
	AST_LOCK: assert property (
		s_low |=> (lockout_o || overtemp_o) && !power_led_o)
		else $error("undervoltage lockout missing");
	AST_RESTART: assert property (
		ce_i && lockout_o && supply_mv_i >= SUPPLY_RUN_MV |=> overtemp_o || power_led_o)
		else $error("restart from lockout missing");
endmodule : pem_checker

bind parameter_error_monitor pem_checker u_pem_checker (.*);

// ### bench/tb.sv
// self-checking bench for the parameter error monitor
`timescale 1ns/100ps
module tb;
	import pem_pkg::*;
	logic              clock_i = 0, arst_n_i = 0, ce_i = 1;
	logic [SET_W-1:0]  h_offset_i, width_i, v_offset_i, height_i, bandwidth_i, exposure_i;
	logic [SET_W-1:0]  gain_i, brightness_i, balance_ub_i, balance_vr_i, supply_mv_i = 16'h2EE0;
	logic [CODE_W-1:0] colour_code_i, trig_polarity_i, trig_source_i, trig_mode_i;
	logic [TEMP_W-1:0] processor_temp_raw_i, board_temp_raw_i;
	logic [TEMP_W-1:0] processor_temp_reading_o, board_temp_reading_o;
	logic              window_format_fault_o, bandwidth_fault_o, exposure_fault_o;
	logic              gain_fault_o, brightness_fault_o, trigger_setup_fault_o;
	logic              colour_balance_fault_o, overtemp_o, lockout_o, power_gen_en_o;
	logic              power_led_o, core_reset_n_o;
	int                seed = 32'hdaf8, mismatches = 0, samples_checked = 0, cycles = 0;

	parameter_error_monitor u_parameter_error_monitor (.*);

	// clock and hang guard
	always #12.5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	function automatic logic win_exp();
		return h_offset_i > 16'h028F || !(width_i inside {[1:16'h0290]}) || v_offset_i > 16'h01EA
			|| !(height_i inside {[1:16'h01EB]}) || colour_code_i > 4'h3
			|| 17'(h_offset_i) + 17'(width_i) > 17'h0290 || 17'(v_offset_i) + 17'(height_i) > 17'h01EB;
	endfunction : win_exp
	function automatic logic trg_exp();
		return trig_polarity_i > 4'h1 || trig_source_i > 4'h2 || trig_mode_i > 4'h2
			|| ((trig_mode_i == 4'h0) != (trig_source_i == 4'h0))
			|| (trig_mode_i == 4'h2 && trig_source_i == 4'h2);
	endfunction : trg_exp

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// random settings; first draws sweep every trigger code and window edges
	task automatic rnd(input logic [5:0] i, input bit corner, input bit check);
		logic edge_win;
		edge_win = corner && (i < 6'h04);
		@(posedge clock_i);
		h_offset_i <= edge_win ? 16'(i[0]) : 16'($random(seed)) & 16'h03FF;
		width_i <= edge_win ? 16'h0290 - 16'(i[1]) : 16'($random(seed)) & 16'h03FF;
		v_offset_i <= 16'($random(seed)) & 16'h01FF;
		height_i <= 16'($random(seed)) & 16'h03FF;
		colour_code_i <= 4'($random(seed)) & 4'h7;
		bandwidth_i <= 16'($random(seed)) & 16'h007F;
		exposure_i <= corner ? 16'(i[0]) : 16'($random(seed)) & 16'h1FFF;
		gain_i <= corner ? 16'h03FF + 16'(i[1]) : 16'($random(seed)) & 16'h07FF;
		brightness_i <= 16'($random(seed)) & 16'h01FF;
		balance_ub_i <= 16'($random(seed)) & 16'h03FF;
		balance_vr_i <= 16'($random(seed)) & 16'h03FF;
		trig_polarity_i <= corner ? 4'(i[5:4]) : 4'($random(seed)) & 4'h3;
		trig_source_i <= corner ? 4'(i[3:2]) : 4'($random(seed)) & 4'h3;
		trig_mode_i <= corner ? 4'(i[1:0]) : 4'($random(seed)) & 4'h3;
		processor_temp_raw_i <= 8'($random(seed)) & 8'h3F;
		board_temp_raw_i <= 8'($random(seed)) & 8'h3F;
		@(posedge clock_i);
		#1;
		// flags are held cleared in reset, so only compare once running
		if (check) begin
			chk("window", 16'(win_exp()), 16'(window_format_fault_o));
			chk("bandwidth", 16'(!(bandwidth_i inside {[1:100]})), 16'(bandwidth_fault_o));
			chk("trigger", 16'(trg_exp()), 16'(trigger_setup_fault_o));
			chk("exposure", 16'(exposure_i == 0 || exposure_i > 16'h0FFF), 16'(exposure_fault_o));
			chk("gain", 16'(gain_i > 16'h03FF), 16'(gain_fault_o));
			chk("brightness", 16'(brightness_i > 16'h00FF), 16'(brightness_fault_o));
			chk("balance", 16'(balance_ub_i > 16'h01FF || balance_vr_i > 16'h01FF),
				16'(colour_balance_fault_o));
			chk("cpu temp", 16'(processor_temp_raw_i), 16'(processor_temp_reading_o));
			chk("brd temp", 16'(board_temp_raw_i), 16'(board_temp_reading_o));
		end
	endtask : rnd

	// enable low freezes every flop; the flags catch up once it returns
	task automatic freeze();
		@(posedge clock_i);
		gain_i <= 16'h0000;
		board_temp_raw_i <= 8'h11;
		@(posedge clock_i);
		ce_i <= 1'b0;
		gain_i <= 16'h0400;
		board_temp_raw_i <= 8'h22;
		repeat (3) @(posedge clock_i);
		#1;
		chk("frozen gain", 16'h0000, 16'(gain_fault_o));
		chk("frozen temp", 16'h0011, 16'(board_temp_reading_o));
		@(posedge clock_i);
		ce_i <= 1'b1;
		@(posedge clock_i);
		#1;
		chk("gain after enable", 16'h0001, 16'(gain_fault_o));
		chk("temp after enable", 16'h0022, 16'(board_temp_reading_o));
		$display("test enable done");
	endtask : freeze

	// supply and temperature step; status is {overtemp, lockout, led, power}
	task automatic pwr(input logic [15:0] mv, input logic [7:0] t, input logic [3:0] exp);
		@(posedge clock_i);
		supply_mv_i <= mv;
		board_temp_raw_i <= t;
		repeat (3) @(posedge clock_i);
		#1;
		chk("power", 16'(exp), 16'({overtemp_o, lockout_o, power_led_o, power_gen_en_o}));
	endtask : pwr

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	initial begin
		rnd(6'h0, 1'b0, 1'b0);
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 300; i++) rnd(6'(i), i < 64, 1'b1);
		$display("test flags done");
		freeze();
		for (int n = 0; n < 5000 && core_reset_n_o !== 1'b1; n++) @(posedge clock_i);
		chk("core reset", 16'h0001, 16'(core_reset_n_o));
		pwr(16'h2904, 8'hC8, 4'h3);
		pwr(16'h270F, 8'hC8, 4'h4);
		pwr(16'h2CEB, 8'h45, 4'h4);
		pwr(16'h2CEC, 8'h45, 4'h3);
		pwr(16'h2710, 8'h46, 4'h8);
		pwr(16'h270F, 8'h00, 4'h8);
		$display("test power done");
		@(posedge clock_i);
		arst_n_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		chk("reset status", 16'h0004, 16'({overtemp_o, lockout_o, power_led_o, power_gen_en_o}));
		arst_n_i <= 1'b1;
		processor_temp_raw_i <= 8'h50;
		pwr(16'h2EE0, 8'h00, 4'h8);
		$display("test cpu heat done");
		summarize();
	end
endmodule : tb
